// [display_output_stage_control_bench.sv]
`timescale 1ns/1ps
`include "dosc_regs.svh"
module display_output_stage_control_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_out, blanking, clr, err;
	logic panel_clk, key_match_pin, key_match_oe_n, line_sync_oe_n, frame_sync_oe_n, frame_ref_oe_n;
	logic converter_out_enable, ref_voltage_enable;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] low_mixer_out;
	logic [23:0] pixel_rgb, data_out, data_oe_n, analog_clamp;
	logic [7:0] input_queue_level, sync_out;
	logic [2:0] high_request_priority;
	int miscompares = 0;
	int checks = 0;
	int edges;
	localparam logic [15:0] ADR [13] = '{`DOSC_MIX5_SEL_ADDR, `DOSC_MIX5_TAB_ADDR, `DOSC_MIX6_SEL_ADDR,
		`DOSC_MIX6_TAB_ADDR, `DOSC_MIX7_SEL_ADDR, `DOSC_MIX7_TAB_ADDR, `DOSC_DELAY_ADDR, `DOSC_CLKGATE_ADDR,
		`DOSC_KEY_LOW_ADDR, `DOSC_KEY_HIGH_ADDR, `DOSC_ACLAMP_ADDR, `DOSC_DBLANK_ADDR, `DOSC_OUT_EN_ADDR};
	localparam logic [31:0] MSK [13] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
		32'hffffffff,
		32'hff, 32'hf, 32'h1ffffff, 32'hffffff, 32'hffffff, 32'hffffff, 32'h3fffffff};

	dosc_output_stage i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .seq_out, .low_mixer_out, .blanking, .pixel_rgb, .input_queue_level, .sync_out, .panel_clk,
		.key_match_pin, .key_match_oe_n, .data_out, .data_oe_n, .line_sync_oe_n, .frame_sync_oe_n,
		.frame_ref_oe_n, .analog_clamp, .converter_out_enable, .ref_voltage_enable, .high_request_priority);
	dosc_panel_model i_panel (.panel_clk(panel_clk), .clear(clr), .edges(edges));

	// 4 ns pixel clock
	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end

	// ----------------
	// shared tasks
	// ----------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task report_and_stop;
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	// one apb transfer: setup, then access until pready is sampled high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rdchk

	// ----------------
	// scenarios
	// ----------------
	task t_reset;
		foreach (ADR[i]) rdchk("reset_reg", ADR[i], 32'h0);
		rdchk("reset_prio", `DOSC_PRIO_ADDR, {16'h0, input_queue_level, 8'h73});
		chk("reset_oe", {data_oe_n, line_sync_oe_n, frame_sync_oe_n, frame_ref_oe_n, key_match_oe_n},
			28'hfffffff);
		chk("reset_ana", {converter_out_enable, ref_voltage_enable}, 2'b00);
		apb(1'b0, 16'h3244, 32'h0);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_rd", rd, 32'h0);
	endtask : t_reset

	// mixers 5 and 6 pick table bit 17 or 0, mixer 7 reads an unused code
	task t_mixer;
		wr(`DOSC_MIX5_SEL_ADDR, 32'h1001);
		wr(`DOSC_MIX5_TAB_ADDR, 32'h20000);
		wr(`DOSC_MIX6_SEL_ADDR, 32'h1001);
		wr(`DOSC_MIX6_TAB_ADDR, 32'h20000);
		wr(`DOSC_MIX7_SEL_ADDR, 32'h2);
		wr(`DOSC_MIX7_TAB_ADDR, 32'h1);
		for (int v = 0; v < 2; v++) begin
			@(posedge pclk);
			seq_out <= v[0];
			low_mixer_out <= v[0] ? 5'h15 : 5'h0a;
			tick(2);
			chk("mixers", sync_out[7:5], {1'b1, v[0], v[0]});
			chk("low_mixers", sync_out[4:0], v[0] ? 5'h15 : 5'h0a);
		end
	endtask : t_mixer

	task t_delay;
		wr(`DOSC_DELAY_ADDR, 32'h20);
		@(posedge pclk);
		seq_out <= 1'b0;
		tick(2);
		@(posedge pclk);
		seq_out <= 1'b1;
		tick(1);
		chk("delay_early", sync_out[6:5], 2'b10);
		#2;
		chk("delay_late", sync_out[6:5], 2'b11);
	endtask : t_delay

	task automatic t_clock;
		logic [3:0] ctl [7] = '{4'h0, 4'h8, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4};
		logic tab [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		int cnt [7] = '{8, 4, 0, 8, 8, 0, 8};
		for (int i = 0; i < 7; i++) begin
			wr(`DOSC_MIX7_TAB_ADDR, {31'h0, tab[i]});
			wr(`DOSC_CLKGATE_ADDR, {28'h0, ctl[i]});
			tick(2);
			clr = 1'b1;
			#0.5;
			clr = 1'b0;
			tick(8);
			chk("clk_edges", edges, cnt[i]);
			if (cnt[i] == 8)
				chk("clk_level", panel_clk, !ctl[i][2]);
		end
		wr(`DOSC_CLKGATE_ADDR, 32'h0);
	endtask : t_clock

	task automatic t_key;
		logic [23:0] pix [6] = '{24'h182838, 24'h102030, 24'h203040, 24'h212838, 24'h18282f, 24'h181f38};
		logic hit [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		wr(`DOSC_KEY_HIGH_ADDR, 32'h203040);
		for (int inv = 0; inv < 2; inv++) begin
			wr(`DOSC_KEY_LOW_ADDR, {7'h0, inv[0], 24'h102030});
			foreach (pix[i]) begin
				@(posedge pclk);
				pixel_rgb <= pix[i];
				tick(2);
				chk("key_pin", key_match_pin, hit[i] ^ inv[0]);
			end
		end
	endtask : t_key

	task automatic t_out;
		logic [31:0] en [2] = '{32'h2aa55ac3, 32'h153cc35a};
		foreach (en[i]) begin
			wr(`DOSC_OUT_EN_ADDR, en[i]);
			tick(1);
			chk("data_oe", data_oe_n, {~en[i][23:0]});
			chk("sync_oe", {frame_ref_oe_n, frame_sync_oe_n, line_sync_oe_n}, {~en[i][26:24]});
			chk("misc_oe", {ref_voltage_enable, converter_out_enable, key_match_oe_n},
				{en[i][29:28], ~en[i][27]});
		end
		wr(`DOSC_DBLANK_ADDR, 32'habcdef);
		wr(`DOSC_ACLAMP_ADDR, 32'h123456);
		tick(1);
		chk("aclamp", analog_clamp, 24'h123456);
		@(posedge pclk);
		pixel_rgb <= 24'h445566;
		blanking <= 1'b1;
		tick(2);
		chk("blank", data_out, 24'habcdef);
		@(posedge pclk);
		blanking <= 1'b0;
		tick(2);
		chk("pixel", data_out, 24'h445566);
	endtask : t_out

	task t_prio;
		wr(`DOSC_PRIO_ADDR, 32'hffffff55);
		@(posedge pclk);
		input_queue_level <= 8'h9c;
		rdchk("prio", `DOSC_PRIO_ADDR, 32'h9c55);
		chk("hi_prio", high_request_priority, 3'h5);
	endtask : t_prio

	task t_mask;
		foreach (ADR[i]) begin
			wr(ADR[i], 32'hffffffff);
			rdchk("mask", ADR[i], MSK[i]);
		end
		wr(16'h3244, 32'hffffffff);
		chk("unmapped_wr", err, 1'b1);
	endtask : t_mask

	// main sequence, with a second reset after the last scenario
	initial begin
		{presetn, psel, penable, pwrite, seq_out, blanking, clr} = '0;
		paddr = '0;
		pwdata = '0;
		low_mixer_out = '0;
		pixel_rgb = '0;
		input_queue_level = 8'h3b;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mixer();
		t_delay();
		t_clock();
		t_key();
		t_out();
		t_prio();
		t_mask();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		report_and_stop();
	end
endmodule : display_output_stage_control_bench

// [dosc_output_stage.sv]
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "dosc_regs.svh"

module dosc_output_stage (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic seq_out,
	input wire logic [4:0] low_mixer_out,
	input wire logic blanking,
	input wire logic [23:0] pixel_rgb,
	input wire logic [7:0] input_queue_level,
	output logic [7:0] sync_out,
	output logic panel_clk,
	output logic key_match_pin,
	output logic key_match_oe_n,
	output logic [23:0] data_out,
	output logic [23:0] data_oe_n,
	output logic line_sync_oe_n,
	output logic frame_sync_oe_n,
	output logic frame_ref_oe_n,
	output logic [23:0] analog_clamp,
	output logic converter_out_enable,
	output logic ref_voltage_enable,
	output logic [2:0] high_request_priority
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	dosc_pkg::dosc_word_t mix_sel_r [5:7];
	dosc_pkg::dosc_word_t mix_tab_r [5:7];
	logic [7:0] half_cycle_delay_bits_r;
	logic [3:0] clk_gate_r;
	logic [24:0] key_low_r;
	logic [23:0] key_high_r;
	logic [23:0] analog_clamp_r;
	logic [23:0] digital_blank_word_r;
	logic [29:0] out_en_r;
	logic [2:0] low_prio_r;
	logic [2:0] high_prio_r;
	logic [31:0] rdata_nxt;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// one mixer input selector: zero, sequencer, else zero
	function automatic logic pick_input(input logic [2:0] sel, input logic seq);
		pick_input = (sel == `DOSC_SEL_SEQ) ? seq : 1'b0;
	endfunction : pick_input

	// mixer: five selected inputs index the truth table
	function automatic logic mix_eval(input logic [31:0] sel, input logic [31:0] tab, input logic seq);
		logic [4:0] idx;
		idx = {pick_input(sel[14:12], seq), pick_input(sel[11:9], seq), pick_input(sel[8:6], seq),
			pick_input(sel[5:3], seq), pick_input(sel[2:0], seq)};
		mix_eval = tab[idx];
	endfunction : mix_eval

	// inclusive range test for one channel
	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// zero wait states; unmapped addresses answer pslverr
	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !pwrite;

	always_comb begin
		addr_ok = 1'b1;
		rdata_nxt = 32'h0000_0000;
		unique case (paddr)
			`DOSC_MIX5_SEL_ADDR: rdata_nxt = mix_sel_r[5];
			`DOSC_MIX5_TAB_ADDR: rdata_nxt = mix_tab_r[5];
			`DOSC_MIX6_SEL_ADDR: rdata_nxt = mix_sel_r[6];
			`DOSC_MIX6_TAB_ADDR: rdata_nxt = mix_tab_r[6];
			`DOSC_MIX7_SEL_ADDR: rdata_nxt = mix_sel_r[7];
			`DOSC_MIX7_TAB_ADDR: rdata_nxt = mix_tab_r[7];
			`DOSC_DELAY_ADDR: rdata_nxt = {24'h00_0000, half_cycle_delay_bits_r};
			`DOSC_CLKGATE_ADDR: rdata_nxt = {28'h000_0000, clk_gate_r};
			`DOSC_KEY_LOW_ADDR: rdata_nxt = {7'h00, key_low_r};
			`DOSC_KEY_HIGH_ADDR: rdata_nxt = {8'h00, key_high_r};
			`DOSC_ACLAMP_ADDR: rdata_nxt = {8'h00, analog_clamp_r};
			`DOSC_DBLANK_ADDR: rdata_nxt = {8'h00, digital_blank_word_r};
			`DOSC_OUT_EN_ADDR: rdata_nxt = {2'h0, out_en_r};
			`DOSC_PRIO_ADDR: rdata_nxt = {16'h0000, input_queue_level, 1'b0, high_prio_r, 1'b0, low_prio_r};
			default: addr_ok = 1'b0;
		endcase
	end

	// read data registered in setup cycle, valid in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_acc && !penable) begin
			prdata <= rdata_nxt;
		end
	end

	assign pslverr = psel && penable && !addr_ok;

	// mixer registers, no documented reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 5; i <= 7; i++) begin
				mix_sel_r[i] <= `DOSC_ZERO_RST;
				mix_tab_r[i] <= `DOSC_ZERO_RST;
			end
		end else if (wr_acc) begin
			for (int i = 5; i <= 7; i++) begin
				if (paddr == 16'(`DOSC_MIX5_SEL_ADDR + 8 * (i - 5))) begin
					mix_sel_r[i] <= pwdata;
				end
				if (paddr == 16'(`DOSC_MIX5_TAB_ADDR + 8 * (i - 5))) begin
					mix_tab_r[i] <= pwdata;
				end
			end
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cycle_delay_bits_r <= 8'h00;
			clk_gate_r <= 4'h0;
			key_low_r <= 25'h000_0000;
			key_high_r <= 24'h00_0000;
			analog_clamp_r <= 24'h00_0000;
			digital_blank_word_r <= 24'h00_0000;
			out_en_r <= 30'h0000_0000;
			low_prio_r <= `DOSC_LOW_PRIO_RST;
			high_prio_r <= `DOSC_HIGH_PRIO_RST;
		end else if (wr_acc) begin
			unique case (paddr)
				`DOSC_DELAY_ADDR: half_cycle_delay_bits_r <= pwdata[7:0];
				`DOSC_CLKGATE_ADDR: clk_gate_r <= pwdata[3:0];
				`DOSC_KEY_LOW_ADDR: key_low_r <= pwdata[24:0];
				`DOSC_KEY_HIGH_ADDR: key_high_r <= pwdata[23:0];
				`DOSC_ACLAMP_ADDR: analog_clamp_r <= pwdata[23:0];
				`DOSC_DBLANK_ADDR: digital_blank_word_r <= pwdata[23:0];
				`DOSC_OUT_EN_ADDR: out_en_r <= pwdata[29:0];
				`DOSC_PRIO_ADDR: begin
					low_prio_r <= pwdata[2:0];
					high_prio_r <= pwdata[6:4];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// sync mixers and half-cycle switch
	// ----------------------------------------
	logic [7:0] mix_raw;
	logic [7:0] mix_q_r;
	logic [7:0] mix_half_r;

	always_comb begin
		mix_raw[4:0] = low_mixer_out;
		for (int i = 5; i <= 7; i++) begin
			mix_raw[i] = mix_eval(mix_sel_r[i], mix_tab_r[i], seq_out);
		end
	end

	// mixer outputs registered on rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mix_q_r <= 8'h00;
		end else begin
			mix_q_r <= mix_raw;
		end
	end

	// falling edge copy gives the half-cycle delay
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			mix_half_r <= 8'h00;
		end else begin
			mix_half_r <= mix_q_r;
		end
	end

	assign sync_out = (half_cycle_delay_bits_r & mix_half_r) | (~half_cycle_delay_bits_r & mix_q_r);

	// ----------------------------------------
	// panel clock
	// ----------------------------------------
	logic half_clk_r;
	logic gate_q_r;
	logic base_clk;
	logic gated_clk;

	// divide by two toggle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_clk_r <= 1'b0;
		end else begin
			half_clk_r <= ~half_clk_r;
		end
	end

	// gate sampled while clock low to keep undivided pclk pulses whole; halved clock pulses can be cut
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q_r <= 1'b0;
		end else begin
			gate_q_r <= mix_q_r[7];
		end
	end

	always_comb begin
		base_clk = clk_gate_r[`DOSC_CLK_HALF_BIT] ? half_clk_r : pclk;
		if (!clk_gate_r[`DOSC_GATE_ON_BIT]) begin
			gated_clk = base_clk;
		end else if (clk_gate_r[`DOSC_GATE_TYPE_BIT]) begin
			gated_clk = base_clk | gate_q_r;
		end else begin
			gated_clk = base_clk & gate_q_r;
		end
		panel_clk = gated_clk ^ clk_gate_r[`DOSC_CLK_INV_BIT];
	end

	// ----------------------------------------
	// colour key and data outputs
	// ----------------------------------------
	logic key_hit;

	assign key_hit = in_range(pixel_rgb[23:16], key_low_r[23:16], key_high_r[23:16])
		&& in_range(pixel_rgb[15:8], key_low_r[15:8], key_high_r[15:8])
		&& in_range(pixel_rgb[7:0], key_low_r[7:0], key_high_r[7:0]);

	// key pin and data word registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_match_pin <= 1'b0;
			data_out <= 24'h00_0000;
		end else begin
			key_match_pin <= key_hit ^ key_low_r[`DOSC_KEY_INV_BIT];
			data_out <= blanking ? digital_blank_word_r : pixel_rgb;
		end
	end

	assign analog_clamp = analog_clamp_r;
	assign data_oe_n = ~out_en_r[23:0];
	assign line_sync_oe_n = ~out_en_r[`DOSC_HS_EN_BIT];
	assign frame_sync_oe_n = ~out_en_r[`DOSC_VS_EN_BIT];
	assign frame_ref_oe_n = ~out_en_r[`DOSC_VR_EN_BIT];
	assign key_match_oe_n = ~out_en_r[`DOSC_KEY_EN_BIT];
	assign converter_out_enable = out_en_r[`DOSC_DAC_EN_BIT];
	assign ref_voltage_enable = out_en_r[`DOSC_REF_EN_BIT];
	assign high_request_priority = high_prio_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// mixer evaluation, selectors and half-cycle switch
	mixer_eval_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (mix_q_r[7] == $past(mix_tab_r[7][{pick_input(mix_sel_r[7][14:12], seq_out),
			pick_input(mix_sel_r[7][11:9], seq_out), pick_input(mix_sel_r[7][8:6], seq_out),
			pick_input(mix_sel_r[7][5:3], seq_out), pick_input(mix_sel_r[7][2:0], seq_out)}])))
		else $error("mixer seven output wrong");
	zero_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mix_sel_r[5][14:0] == 15'h0000) |=> (mix_q_r[5] == $past(mix_tab_r[5][0])))
		else $error("zero selects not index zero");
	half_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (mix_half_r == mix_q_r))
		else $error("half cycle copy wrong");
	undelayed_a: assert property (@(posedge pclk) disable iff (!presetn)
		!half_cycle_delay_bits_r[6] |-> (sync_out[6] == mix_q_r[6]))
		else $error("undelayed sync differs");
	delay_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_DELAY_ADDR) |=> (half_cycle_delay_bits_r == $past(pwdata[7:0])))
		else $error("delay bits not written");

	// register write effects on pins, and the queue level read
	enable_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_OUT_EN_ADDR) |=> (converter_out_enable == $past(pwdata[28])))
		else $error("converter enable wrong");
	key_oe_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_OUT_EN_ADDR) |=> ((key_match_oe_n == !$past(pwdata[27]))
			&& (ref_voltage_enable == $past(pwdata[29]))))
		else $error("key or reference enable wrong");
	data_oe_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_OUT_EN_ADDR) |=> (data_oe_n == ~$past(pwdata[23:0])))
		else $error("data enables wrong");
	sync_oe_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_OUT_EN_ADDR) |=> ({frame_ref_oe_n, frame_sync_oe_n, line_sync_oe_n} == ~$past(pwdata[26:24])))
		else $error("sync enables wrong");
	clamp_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_ACLAMP_ADDR) |=> (analog_clamp == $past(pwdata[23:0])))
		else $error("analog clamp wrong");
	prio_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == `DOSC_PRIO_ADDR) |=> (high_request_priority == $past(pwdata[6:4])))
		else $error("high priority wrong");
	prio_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == `DOSC_PRIO_ADDR) |=> (prdata[15:8] == $past(input_queue_level)))
		else $error("queue level not read");

	// panel clock path
	half_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (half_clk_r != $past(half_clk_r)))
		else $error("divider not toggling");
	halve_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_gate_r == 4'h8) |-> (panel_clk == half_clk_r))
		else $error("halved clock not sent");
	clock_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_gate_r[3:1] == 3'h0) |-> !panel_clk)
		else $error("ungated clock not passed");
	clock_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_gate_r[3:1] == 3'h2) |-> panel_clk)
		else $error("clock not inverted");
	gate_source_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (gate_q_r == mix_q_r[7]))
		else $error("gate not from mixer seven");
	gate_and_a: assert property (@(negedge pclk) disable iff (!presetn)
		(clk_gate_r == 4'h2) |-> (panel_clk == gate_q_r))
		else $error("and gate wrong");
	gate_or_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_gate_r == 4'h3) |-> (panel_clk == gate_q_r))
		else $error("or gate wrong");

	// colour key and data word
	key_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!key_low_r[24] && (pixel_rgb[7:0] < key_low_r[7:0])) ##1 !key_low_r[24] |-> !key_match_pin)
		else $error("key active out of range");
	key_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!key_low_r[24] && (pixel_rgb[23:16] > key_high_r[23:16])) ##1 !key_low_r[24] |-> !key_match_pin)
		else $error("key active above range");
	key_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (key_match_pin == ($past(key_hit) ^ $past(key_low_r[24]))))
		else $error("key polarity wrong");
	blank_word_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(blanking) |-> (data_out == $past(digital_blank_word_r)))
		else $error("blank word not driven");
	data_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		($past(presetn) && !$past(blanking)) |-> (data_out == $past(pixel_rgb)))
		else $error("pixel word not driven");

endmodule : dosc_output_stage

// [dosc_panel_model.sv]
`timescale 1ns/1ps
// ----------------
// panel side model
// ----------------
module dosc_panel_model (
	input wire logic panel_clk,
	input wire logic clear,
	output int edges
);
	// counts rising clock edges reaching the panel, cleared by the bench
	always @(posedge panel_clk or posedge clear) begin
		if (clear)
			edges <= 0;
		else
			edges <= edges + 1;
	end
endmodule : dosc_panel_model

// [dosc_pkg.sv]
package dosc_pkg;
	typedef logic [31:0] dosc_word_t;
	typedef logic [7:0] dosc_chan_t;
	// apb slave phases
	typedef enum logic [2:0] {
		DOSC_IDLE = 3'b001,
		DOSC_SETUP = 3'b010,
		DOSC_ACCESS = 3'b100
	} dosc_apb_t;
endpackage : dosc_pkg

// [dosc_regs.svh]
`ifndef DOSC_REGS_SVH
`define DOSC_REGS_SVH
// register byte addresses
`define DOSC_MIX5_SEL_ADDR 16'h3228
`define DOSC_MIX5_TAB_ADDR 16'h322c
`define DOSC_MIX6_SEL_ADDR 16'h3230
`define DOSC_MIX6_TAB_ADDR 16'h3234
`define DOSC_MIX7_SEL_ADDR 16'h3238
`define DOSC_MIX7_TAB_ADDR 16'h323c
`define DOSC_DELAY_ADDR 16'h3240
`define DOSC_CLKGATE_ADDR 16'h3248
`define DOSC_KEY_LOW_ADDR 16'h3250
`define DOSC_KEY_HIGH_ADDR 16'h3254
`define DOSC_ACLAMP_ADDR 16'h3258
`define DOSC_DBLANK_ADDR 16'h325c
`define DOSC_OUT_EN_ADDR 16'h3260
`define DOSC_PRIO_ADDR 16'h3270
// clock gate control bits
`define DOSC_GATE_TYPE_BIT 0
`define DOSC_GATE_ON_BIT 1
`define DOSC_CLK_INV_BIT 2
`define DOSC_CLK_HALF_BIT 3
// key limit fields
`define DOSC_KEY_INV_BIT 24
// output enable bits
`define DOSC_HS_EN_BIT 24
`define DOSC_VS_EN_BIT 25
`define DOSC_VR_EN_BIT 26
`define DOSC_KEY_EN_BIT 27
`define DOSC_DAC_EN_BIT 28
`define DOSC_REF_EN_BIT 29
// reset values and the sequencer select code
`define DOSC_ZERO_RST 32'h0000_0000
`define DOSC_LOW_PRIO_RST 3'h3
`define DOSC_HIGH_PRIO_RST 3'h7
`define DOSC_SEL_SEQ 3'h1
`endif
